// >>> core/switch_cfg_pkg.sv
// Constants, types and operating notes of the switch lookup global configuration bank.
// Operation
// R1: Two read-write byte registers hold switch MAC address bits 15:8 and 7:0, each reset to 0xFF.
// R2: A 14-bit read-write maximum payload length sits in the low bits of a 16-bit register, reset 2000.
// R3: Any frame whose payload runs past the programmed maximum length is truncated.
// R4: Software may program the maximum payload length up to 9000 bytes for jumbo frames.
// R5: The 16-bit tag type, reset 0x9100, tags untagged frames and is the outer tag when double tagging.
// R6: Lookup control 0 bit 7 is the VLAN master enable, one enables VLAN mode, reset zero.
// R7: Software fills the VLAN table completely before it sets the VLAN master enable.
// R8: Bit 6 set (reset one) drops packets with an invalid VLAN ID, clear sends them to the host port.
// R9: Unknown-VID forwarding, when enabled, takes precedence over the invalid-VID setting.
// R10: Bits 5:3 hold a 3-bit age count, reset 100b, loaded into a dynamic entry on each update.
// R11: The aging time of dynamic entries comes from the age count combined with the age period.
// R12: Bit 2 enables reserved multicast table lookups when one, reset zero.
// R13: Hash select 00 or 11 indexes the dynamic table with the ten lowest destination address bits.
// R14: Hash select 01, the reset value, maps dynamic entries with a CRC hash of the address.
// R15: Hash select 10 maps dynamic entries with an XOR hash of the address.
// R16: The six-byte switch MAC address is the pause frame source and the self-filter address.
// R17: Reserved bits 15:14 of the length register are writable and readable and do nothing.
package switch_cfg_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam int unsigned ADDR_W        = 16;
   localparam logic [15:0] OFS_MAC_BYTE4 = 16'h0306;
   localparam logic [15:0] OFS_MAC_BYTE5 = 16'h0307;
   localparam logic [15:0] OFS_MAXLEN_HI = 16'h0308;
   localparam logic [15:0] OFS_MAXLEN_LO = 16'h0309;
   localparam logic [15:0] OFS_TPID_HI   = 16'h030A;
   localparam logic [15:0] OFS_TPID_LO   = 16'h030B;
   localparam logic [15:0] OFS_LKCTL0    = 16'h0310;

   // ****************************************************************
   // Reset values and limits
   // ****************************************************************
   localparam logic [7:0]  RST_MAC_BYTE  = 8'hFF;
   localparam logic [15:0] RST_MAXLEN    = 16'h07D0;
   localparam logic [15:0] RST_TPID      = 16'h9100;
   localparam logic [7:0]  RST_LKCTL0    = 8'h61;
   localparam logic [13:0] JUMBO_MAXLEN  = 14'h2328;
   localparam logic [7:0]  UNMAPPED_READ = 8'h00;

   // ****************************************************************
   // Field positions and widths
   // ****************************************************************
   localparam int unsigned MAXLEN_W        = 14;
   localparam int unsigned LK_VLAN_EN      = 7;
   localparam int unsigned LK_DROP_INVALID = 6;
   localparam int unsigned LK_AGE_HI       = 5;
   localparam int unsigned LK_AGE_LO       = 3;
   localparam int unsigned LK_RSVD_MC      = 2;
   localparam int unsigned LK_HASH_HI      = 1;
   localparam int unsigned LK_HASH_LO      = 0;
   localparam int unsigned AGE_W           = 3;
   localparam int unsigned HASH_W          = 10;

   // ****************************************************************
   // Hash selection and hash constants
   // ****************************************************************
   localparam logic [1:0]  HASH_DIRECT0 = 2'h0;
   localparam logic [1:0]  HASH_CRC     = 2'h1;
   localparam logic [1:0]  HASH_XOR     = 2'h2;
   localparam logic [1:0]  HASH_DIRECT3 = 2'h3;
   localparam logic [9:0]  CRC_POLY     = 10'h233;
   localparam logic [9:0]  CRC_INIT     = 10'h3FF;

   typedef logic [1:0] hash_sel_t;

   typedef enum logic [1:0] {
      VERDICT_FORWARD,
      VERDICT_DROP,
      VERDICT_HOST,
      VERDICT_UNKNOWN
   } verdict_t;

endpackage

// >>> core/lookup_hash_if.sv
// Interface between the configuration bank and its dynamic table hash unit.
`timescale 1ns/1ps
interface lookup_hash_if;
   import switch_cfg_pkg::*;
   logic [47:0]       dstMac;
   hash_sel_t         hashSel;
   logic [HASH_W-1:0] tableIndex;
   modport requester (output dstMac, output hashSel, input tableIndex);
   modport hasher (input dstMac, input hashSel, output tableIndex);
endinterface

// >>> core/lookup_hash_unit.sv
// Combinational dynamic table index generator: direct, CRC or XOR mapping.
`timescale 1ns/1ps
module lookup_hash_unit
   import switch_cfg_pkg::*;
(
   lookup_hash_if.hasher hsh
);

   // ****************************************************************
   // Hash functions
   // ****************************************************************
   // Bit-serial CRC over the 48 address bits; it is deep logic, so the
   // caller registers the result before anyone uses it.
   function automatic logic [HASH_W-1:0] crcHash(input logic [47:0] a);
      logic [HASH_W-1:0] c;
      logic              fb;
      c = CRC_INIT;
      for (int i = 47; i >= 0; i--) begin
         fb = c[HASH_W-1] ^ a[i];
         c  = {c[HASH_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction

   function automatic logic [HASH_W-1:0] xorHash(input logic [47:0] a);
      logic [HASH_W-1:0] x;
      x = a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'h0, a[47:40]};
      return x;
   endfunction

   // ****************************************************************
   // Index selection
   // ****************************************************************
   wire logic [HASH_W-1:0] directIdx = hsh.dstMac[HASH_W-1:0];
   wire logic [HASH_W-1:0] crcIdx    = crcHash(hsh.dstMac);
   wire logic [HASH_W-1:0] xorIdx    = xorHash(hsh.dstMac);

   assign hsh.tableIndex = (hsh.hashSel == HASH_CRC) ? crcIdx :  // R14
                           (hsh.hashSel == HASH_XOR) ? xorIdx :  // R15
                           directIdx;                            // R13

endmodule // lookup_hash_unit

// >>> core/switch_lookup_global_config.sv
// Global switch configuration bank: MAC low bytes, payload limit, tag type, lookup control 0.
`timescale 1ns/1ps
module switch_lookup_global_config
   import switch_cfg_pkg::*;
#(
   parameter int unsigned AGE_PERIOD_W = 8
)(
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic [ADDR_W-1:0]       regAddr,
   input  wire logic [7:0]              regWrData,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   output logic [7:0]                   regRdData,
   output logic                         regRdValid,
   input  wire logic [31:0]             macUpper,
   output logic [47:0]                  pauseSrcMac,
   input  wire logic                    srcCheck,
   input  wire logic [47:0]             srcMac,
   output logic                         selfAddrHit,
   input  wire logic                    payByteValid,
   input  wire logic                    payFirst,
   output logic                         payByteOut,
   output logic                         payByteKeep,
   output logic                         frameTruncated,
   input  wire logic                    doubleTagEn,
   input  wire logic                    frmTagged,
   input  wire logic [15:0]             frmTpid,
   output logic [15:0]                  ingressTagType,
   output logic [15:0]                  outerTagType,
   output logic                         outerTagInsert,
   input  wire logic                    vidCheck,
   input  wire logic                    vidInvalid,
   input  wire logic                    unknownVidFwdEn,
   output verdict_t                     vidVerdict,
   output logic                         vidVerdictValid,
   output logic                         vlanEnable,
   output logic                         rsvdMcLookupEn,
   input  wire logic                    entryUpdate,
   output logic [AGE_W-1:0]             entryAgeLoad,
   output logic                         entryAgeValid,
   input  wire logic [AGE_PERIOD_W-1:0] agePeriod,
   output logic [AGE_W+AGE_PERIOD_W-1:0] agingTime,
   input  wire logic                    dstCheck,
   input  wire logic [47:0]             dstMac,
   output logic [HASH_W-1:0]            tableIndex,
   output logic                         tableIndexValid
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [7:0]  macByte4;
   logic [7:0]  macByte5;
   logic [15:0] max_frame_payload_len;
   logic [15:0] provider_outer_tag;
   logic [7:0]  lookupCtl0;
   logic [14:0] payCount;

   // ****************************************************************
   // Register decode
   // ****************************************************************
   wire logic wrMac4  = regWrite && (regAddr == OFS_MAC_BYTE4);
   wire logic wrMac5  = regWrite && (regAddr == OFS_MAC_BYTE5);
   wire logic wrLenHi = regWrite && (regAddr == OFS_MAXLEN_HI);
   wire logic wrLenLo = regWrite && (regAddr == OFS_MAXLEN_LO);
   wire logic wrTpHi  = regWrite && (regAddr == OFS_TPID_HI);
   wire logic wrTpLo  = regWrite && (regAddr == OFS_TPID_LO);
   wire logic wrLk0   = regWrite && (regAddr == OFS_LKCTL0);

   wire logic [7:0] next_rdData =
      (regAddr == OFS_MAC_BYTE4) ? macByte4 :
      (regAddr == OFS_MAC_BYTE5) ? macByte5 :
      (regAddr == OFS_MAXLEN_HI) ? max_frame_payload_len[15:8] :
      (regAddr == OFS_MAXLEN_LO) ? max_frame_payload_len[7:0] :
      (regAddr == OFS_TPID_HI)   ? provider_outer_tag[15:8] :
      (regAddr == OFS_TPID_LO)   ? provider_outer_tag[7:0] :
      (regAddr == OFS_LKCTL0)    ? lookupCtl0 :
      UNMAPPED_READ;

   // ****************************************************************
   // Lookup control 0 fields
   // ****************************************************************
   wire logic             cfgVlanEn   = lookupCtl0[LK_VLAN_EN];
   wire logic             cfgDropInv  = lookupCtl0[LK_DROP_INVALID];
   wire logic [AGE_W-1:0] cfgAgeCount = lookupCtl0[LK_AGE_HI:LK_AGE_LO];
   wire logic             cfgRsvdMc   = lookupCtl0[LK_RSVD_MC];
   wire hash_sel_t        cfgHashSel  = lookupCtl0[LK_HASH_HI:LK_HASH_LO];
   wire logic [MAXLEN_W-1:0] cfgMaxLen = max_frame_payload_len[MAXLEN_W-1:0];

   // ****************************************************************
   // Derived datapath values
   // ****************************************************************
   // Bits 15:14 never reach the limit compare, so they can hold anything.
   wire logic [14:0] maxLimit = {1'b0, cfgMaxLen};                    // R17
   wire logic [14:0] next_payCount =
      payFirst ? 15'h0001 :
      (payCount == 15'h7FFF) ? payCount : 15'(payCount + 15'h0001);
   wire logic next_keep = next_payCount <= maxLimit;                  // R3
   wire logic next_trunc =
      (payFirst ? 1'b0 : frameTruncated) | (payByteValid & ~next_keep);

   wire verdict_t next_verdict =
      !cfgVlanEn      ? VERDICT_FORWARD :                             // R6
      !vidInvalid     ? VERDICT_FORWARD :
      unknownVidFwdEn ? VERDICT_UNKNOWN :                             // R9
      cfgDropInv      ? VERDICT_DROP : VERDICT_HOST;                  // R8

   wire logic [47:0] fullMac = {macUpper, macByte4, macByte5};        // R16
   wire logic [15:0] next_tagType = frmTagged ? frmTpid : provider_outer_tag; // R5
   wire logic [AGE_W+AGE_PERIOD_W-1:0] next_agingTime =
      {{AGE_PERIOD_W{1'b0}}, cfgAgeCount} * {{AGE_W{1'b0}}, agePeriod}; // R11

   lookup_hash_if hashBus ();
   assign hashBus.dstMac  = dstMac;
   assign hashBus.hashSel = cfgHashSel;

   lookup_hash_unit hashUnit (
      .hsh (hashBus)
   );

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   // Jumbo limits up to 9000 fit the 14-bit field; nothing clamps a larger
   // value, so software owns keeping within that range.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         macByte4              <= RST_MAC_BYTE;                       // R1
         macByte5              <= RST_MAC_BYTE;                       // R1
         max_frame_payload_len <= RST_MAXLEN;                         // R2
         provider_outer_tag    <= RST_TPID;                           // R5
         lookupCtl0            <= RST_LKCTL0;                         // R6
      end else begin
         if (wrMac4) begin
            macByte4 <= regWrData;                                    // R1
         end
         if (wrMac5) begin
            macByte5 <= regWrData;                                    // R1
         end
         if (wrLenHi) begin
            max_frame_payload_len[15:8] <= regWrData;                 // R2
         end
         if (wrLenLo) begin
            max_frame_payload_len[7:0] <= regWrData;                  // R2
         end
         if (wrTpHi) begin
            provider_outer_tag[15:8] <= regWrData;
         end
         if (wrTpLo) begin
            provider_outer_tag[7:0] <= regWrData;
         end
         if (wrLk0) begin
            lookupCtl0 <= regWrData;                                  // R12
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdData  <= regRead ? next_rdData : regRdData;
         regRdValid <= regRead;
      end
   end

   // ****************************************************************
   // Payload truncation
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         payCount       <= 15'h0000;
         payByteOut     <= 1'b0;
         payByteKeep    <= 1'b0;
         frameTruncated <= 1'b0;
      end else begin
         if (payByteValid) begin
            payCount <= next_payCount;
         end
         payByteOut     <= payByteValid;
         payByteKeep    <= payByteValid & next_keep;                  // R3
         frameTruncated <= next_trunc;                                // R3
      end
   end

   // ****************************************************************
   // Tagging, VLAN verdict, aging and address outputs
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ingressTagType  <= RST_TPID;
         outerTagType    <= 16'h0000;
         outerTagInsert  <= 1'b0;
         vidVerdict      <= VERDICT_FORWARD;
         vidVerdictValid <= 1'b0;
         vlanEnable      <= 1'b0;
         rsvdMcLookupEn  <= 1'b0;
         entryAgeLoad    <= '0;
         entryAgeValid   <= 1'b0;
         agingTime       <= '0;
         pauseSrcMac     <= 48'h0000_0000_0000;
         selfAddrHit     <= 1'b0;
         tableIndex      <= '0;
         tableIndexValid <= 1'b0;
      end else begin
         ingressTagType  <= next_tagType;                             // R5
         outerTagType    <= doubleTagEn ? provider_outer_tag : 16'h0000; // R5
         outerTagInsert  <= doubleTagEn;
         vidVerdict      <= vidCheck ? next_verdict : vidVerdict;     // R8
         vidVerdictValid <= vidCheck;
         vlanEnable      <= cfgVlanEn;                                // R6
         rsvdMcLookupEn  <= cfgRsvdMc;                                // R12
         entryAgeLoad    <= entryUpdate ? cfgAgeCount : entryAgeLoad; // R10
         entryAgeValid   <= entryUpdate;                              // R10
         agingTime       <= next_agingTime;                           // R11
         pauseSrcMac     <= fullMac;                                  // R16
         selfAddrHit     <= srcCheck && (srcMac == fullMac);          // R16
         tableIndex      <= dstCheck ? hashBus.tableIndex : tableIndex;
         tableIndexValid <= dstCheck;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_mac_byte_write: assert property (@(posedge clk) disable iff (sys_rst) // R1
      wrMac4 |=> ##1 pauseSrcMac[15:8] == $past(regWrData, 2))
      else $error("MAC byte write did not reach the pause source address.");

   a_len_reserved_bits: assert property (@(posedge clk) disable iff (sys_rst) // R17
      wrLenHi |=> max_frame_payload_len[15:14] == $past(regWrData[7:6]))
      else $error("Reserved length bits did not hold the written value.");

   a_trunc_over_limit: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (payByteValid && !payFirst && payCount >= maxLimit) |=> !payByteKeep && frameTruncated)
      else $error("Byte past the payload limit was kept.");

   a_tag_untagged: assert property (@(posedge clk) disable iff (sys_rst) // R5
      !frmTagged |=> ingressTagType == $past(provider_outer_tag))
      else $error("Untagged frame did not get the programmed tag type.");

   a_vlan_off_forward: assert property (@(posedge clk) disable iff (sys_rst) // R6
      (vidCheck && !cfgVlanEn) |=> vidVerdictValid && vidVerdict == VERDICT_FORWARD)
      else $error("VLAN disabled but verdict was not forward.");

   a_invalid_vid_action: assert property (@(posedge clk) disable iff (sys_rst) // R8
      (vidCheck && cfgVlanEn && vidInvalid && !unknownVidFwdEn)
      |=> vidVerdict == ($past(cfgDropInv) ? VERDICT_DROP : VERDICT_HOST))
      else $error("Invalid VLAN ID verdict does not follow the drop bit.");

   a_unknown_vid_wins: assert property (@(posedge clk) disable iff (sys_rst) // R9
      (vidCheck && cfgVlanEn && vidInvalid && unknownVidFwdEn)
      |=> vidVerdict == VERDICT_UNKNOWN)
      else $error("Unknown VLAN forwarding did not take precedence.");

   a_age_count_load: assert property (@(posedge clk) disable iff (sys_rst) // R10
      entryUpdate |=> entryAgeValid && entryAgeLoad == $past(lookupCtl0[5:3]))
      else $error("Updated entry did not receive the programmed age count.");

   a_hash_direct_map: assert property (@(posedge clk) disable iff (sys_rst) // R13
      (dstCheck && (cfgHashSel == HASH_DIRECT0 || cfgHashSel == HASH_DIRECT3))
      |=> tableIndex == $past(dstMac[9:0]))
      else $error("Direct mapping did not use the low destination bits.");

   a_hash_xor_map: assert property (@(posedge clk) disable iff (sys_rst) // R15
      (dstCheck && cfgHashSel == HASH_XOR) |=> tableIndex == $past(
      dstMac[9:0] ^ dstMac[19:10] ^ dstMac[29:20] ^ dstMac[39:30] ^ {2'h0, dstMac[47:40]}))
      else $error("XOR mapping produced the wrong index.");

   a_len_low_write: assert property (@(posedge clk) disable iff (sys_rst) // R2
      wrLenLo |=> max_frame_payload_len[7:0] == $past(regWrData))
      else $error("Length low byte write was lost.");

   a_keep_in_limit: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (payByteValid && !payFirst && payCount < maxLimit) |=> payByteKeep)
      else $error("Byte within the payload limit was cut.");

   a_outer_tag_type: assert property (@(posedge clk) disable iff (sys_rst) // R5
      doubleTagEn |=> outerTagInsert && outerTagType == $past(provider_outer_tag))
      else $error("Outer tag type is not the programmed one.");

   a_aging_time: assert property (@(posedge clk) disable iff (sys_rst) // R11
      1'b1 |=> agingTime == $past(cfgAgeCount) * $past(agePeriod))
      else $error("Aging time is not age count times age period.");

   a_rsvd_mc_enable: assert property (@(posedge clk) disable iff (sys_rst) // R12
      1'b1 |=> rsvdMcLookupEn == $past(lookupCtl0[LK_RSVD_MC]))
      else $error("Reserved multicast enable does not follow bit 2.");

   a_self_addr_hit: assert property (@(posedge clk) disable iff (sys_rst) // R16
      srcCheck |=> selfAddrHit == ($past(srcMac) == $past(fullMac)))
      else $error("Self address compare gave the wrong result.");

   a_pause_source: assert property (@(posedge clk) disable iff (sys_rst) // R16
      1'b1 |=> pauseSrcMac == $past(fullMac))
      else $error("Pause source address is not the switch address.");

   a_mac_byte_read: assert property (@(posedge clk) disable iff (sys_rst) // R1
      (regRead && regAddr == OFS_MAC_BYTE5) |=> regRdValid && regRdData == $past(macByte5))
      else $error("MAC byte read returned the wrong value.");

endmodule // switch_lookup_global_config

// >>> bench/switch_lookup_global_config_tb_top.sv
// Self-checking bench of the switch lookup global configuration bank.
`timescale 1ns/1ps
module switch_lookup_global_config_tb_top;
   import switch_cfg_pkg::*;
   // ****************************************************************
   // Bench signals, helpers and scenarios
   // ****************************************************************
   logic        clk = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, srcCheck = 1'h0;
   logic        payByteValid = 1'h0, payFirst = 1'h0, doubleTagEn = 1'h0, frmTagged = 1'h0;
   logic        vidCheck = 1'h0, vidInvalid = 1'h0, unknownVidFwdEn = 1'h0, entryUpdate = 1'h0;
   logic        dstCheck = 1'h0;
   logic [15:0] regAddr = 16'h0000, frmTpid = 16'h8100, ingressTagType, outerTagType;
   logic [7:0]  regWrData = 8'h00, agePeriod = 8'h07, regRdData;
   logic [31:0] macUpper = 32'h0010A1FF;
   logic [47:0] srcMac = 48'h0, dstMac = 48'h0123456789AB, pauseSrcMac;
   logic        regRdValid, selfAddrHit, payByteOut, payByteKeep, frameTruncated, outerTagInsert;
   logic        vidVerdictValid, vlanEnable, rsvdMcLookupEn, entryAgeValid, tableIndexValid;
   logic [2:0]  entryAgeLoad;
   logic [10:0] agingTime;
   logic [9:0]  tableIndex;
   verdict_t    vidVerdict;
   int          n_errors = 0, total_checks = 0;
   always #5 clk = ~clk;
   switch_lookup_global_config #(.AGE_PERIOD_W(8)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
      .macUpper(macUpper), .pauseSrcMac(pauseSrcMac), .srcCheck(srcCheck), .srcMac(srcMac),
      .selfAddrHit(selfAddrHit), .payByteValid(payByteValid), .payFirst(payFirst),
      .payByteOut(payByteOut), .payByteKeep(payByteKeep), .frameTruncated(frameTruncated),
      .doubleTagEn(doubleTagEn), .frmTagged(frmTagged), .frmTpid(frmTpid),
      .ingressTagType(ingressTagType), .outerTagType(outerTagType),
      .outerTagInsert(outerTagInsert), .vidCheck(vidCheck), .vidInvalid(vidInvalid),
      .unknownVidFwdEn(unknownVidFwdEn), .vidVerdict(vidVerdict),
      .vidVerdictValid(vidVerdictValid), .vlanEnable(vlanEnable),
      .rsvdMcLookupEn(rsvdMcLookupEn), .entryUpdate(entryUpdate), .entryAgeLoad(entryAgeLoad),
      .entryAgeValid(entryAgeValid), .agePeriod(agePeriod), .agingTime(agingTime),
      .dstCheck(dstCheck), .dstMac(dstMac), .tableIndex(tableIndex),
      .tableIndexValid(tableIndexValid)
   );
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Inputs move on the falling edge so the rising edge always sees settled values.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrite = 1'h1;
      @(negedge clk);
      regWrite = 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      regAddr = a;
      regRead = 1'h1;
      @(negedge clk);
      regRead = 1'h0;
      chk("read valid", 48'h1, 48'(regRdValid));
      chk($sformatf("register %h", a), 48'(exp), 48'(regRdData));
   endtask
   task automatic t_reset();
      rd(OFS_MAC_BYTE4, 8'hFF);
      rd(OFS_MAC_BYTE5, 8'hFF);
      rd(OFS_MAXLEN_HI, 8'h07);
      rd(OFS_MAXLEN_LO, 8'hD0);
      rd(OFS_TPID_HI, 8'h91);
      rd(OFS_TPID_LO, 8'h00);
      rd(OFS_LKCTL0, 8'h61);
      rd(16'h030C, 8'h00);
      chk("pause source", {macUpper, 16'hFFFF}, pauseSrcMac);
      chk("outer tag off", 48'h0, 48'(outerTagType));
      $display("Test reset values done");
   endtask
   task automatic t_mac();
      wr(OFS_MAC_BYTE4, 8'h5A);
      wr(OFS_MAC_BYTE5, 8'hC3);
      wr(OFS_TPID_HI, 8'h88);
      wr(OFS_TPID_LO, 8'hA8);
      rd(OFS_MAC_BYTE5, 8'hC3);
      doubleTagEn = 1'h1;
      srcMac = {macUpper, 16'h5AC3};
      srcCheck = 1'h1;
      @(negedge clk);
      srcMac[0] = 1'h0;
      chk("self hit", 48'h1, 48'(selfAddrHit));
      chk("pause source", {macUpper, 16'h5AC3}, pauseSrcMac);
      @(negedge clk);
      srcCheck = 1'h0;
      chk("self miss", 48'h0, 48'(selfAddrHit));
      chk("ingress tag", 48'h88A8, 48'(ingressTagType));
      chk("outer tag", 48'h88A8, 48'(outerTagType));
      chk("outer insert", 48'h1, 48'(outerTagInsert));
      frmTagged = 1'h1;
      @(negedge clk);
      frmTagged = 1'h0;
      chk("tagged ingress", 48'h8100, 48'(ingressTagType));
      $display("Test address and tag done");
   endtask
   // Limit of two: bytes one and two pass, three is cut, four opens a new frame.
   task automatic t_len();
      wr(OFS_MAXLEN_HI, 8'hC0);
      wr(OFS_MAXLEN_LO, 8'h02);
      rd(OFS_MAXLEN_HI, 8'hC0);
      payByteValid = 1'h1;
      payFirst = 1'h1;
      for (int i = 1; i <= 4; i++) begin
         @(negedge clk);
         payFirst = (i == 3);
         payByteValid = (i < 4);
         chk("byte out", 48'h1, 48'(payByteOut));
         chk("byte kept", 48'(i != 3), 48'(payByteKeep));
         chk("truncated", 48'(i == 3), 48'(frameTruncated));
      end
      wr(OFS_MAXLEN_HI, 8'h23);
      wr(OFS_MAXLEN_LO, 8'h28);
      rd(OFS_MAXLEN_LO, 8'h28);
      $display("Test payload limit done");
   endtask
   task automatic t_vid(input logic [7:0] ctl, input logic inv, input logic unk,
                        input verdict_t exp);
      wr(OFS_LKCTL0, ctl);
      @(negedge clk);
      vidInvalid = inv;
      unknownVidFwdEn = unk;
      vidCheck = 1'h1;
      @(negedge clk);
      vidCheck = 1'h0;
      chk("verdict valid", 48'h1, 48'(vidVerdictValid));
      chk("verdict", 48'(exp), 48'(vidVerdict));
      chk("vlan enable", 48'(ctl[7]), 48'(vlanEnable));
      $display("Test vlan verdict done");
   endtask
   task automatic t_age();
      wr(OFS_LKCTL0, 8'h2D);
      agePeriod = 8'h09;
      @(negedge clk);
      entryUpdate = 1'h1;
      @(negedge clk);
      entryUpdate = 1'h0;
      chk("age valid", 48'h1, 48'(entryAgeValid));
      chk("age load", 48'h5, 48'(entryAgeLoad));
      chk("aging time", 48'h2D, 48'(agingTime));
      chk("reserved mc", 48'h1, 48'(rsvdMcLookupEn));
      $display("Test age count done");
   endtask
   // Computed bit by bit here, independent of the hash unit's own structure.
   function automatic logic [9:0] ref_index(input logic [1:0] sel, input logic [47:0] m);
      logic [9:0] c;
      c = 10'h3FF;
      if (sel == 2'h2) return m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]};
      if (sel != 2'h1) return m[9:0];
      for (int i = 47; i >= 0; i--) c = {c[8:0], 1'h0} ^ ((c[9] ^ m[i]) ? 10'h233 : 10'h000);
      return c;
   endfunction
   task automatic t_hash();
      for (int s = 0; s < 4; s++) begin
         wr(OFS_LKCTL0, {6'h18, 2'(s)});
         @(negedge clk);
         dstCheck = 1'h1;
         @(negedge clk);
         dstCheck = 1'h0;
         chk("index valid", 48'h1, 48'(tableIndexValid));
         chk("table index", 48'(ref_index(2'(s), dstMac)), 48'(tableIndex));
      end
      $display("Test hash select done");
   endtask
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'h0;
      t_reset();
      t_mac();
      t_len();
      t_vid(8'h61, 1'h1, 1'h0, VERDICT_FORWARD);
      t_vid(8'hE1, 1'h0, 1'h0, VERDICT_FORWARD);
      t_vid(8'hE1, 1'h1, 1'h0, VERDICT_DROP);
      t_vid(8'hA1, 1'h1, 1'h0, VERDICT_HOST);
      t_vid(8'hA1, 1'h1, 1'h1, VERDICT_UNKNOWN);
      t_age();
      t_hash();
      finish_test();
   end
endmodule // switch_lookup_global_config_tb_top
